// ===== rtl/ttes_pkg.sv
// constants and carrier types for the transfer trigger enable registers
// assumes a 32-bit APB slave port with a 12-bit byte offset inside the control unit
package ttes_pkg;

   // ------------------------------------------------------------------
   // bus geometry
   // ------------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_STATUS_LOW  = 12'h300;
   localparam logic [ADDR_W-1:0] OFF_STATUS_HIGH = 12'h304;
   localparam logic [ADDR_W-1:0] OFF_SET_LOW     = 12'h310;
   localparam logic [ADDR_W-1:0] OFF_SET_HIGH    = 12'h314;
   localparam logic [ADDR_W-1:0] OFF_CLEAR_LOW   = 12'h320;
   localparam logic [ADDR_W-1:0] OFF_CLEAR_HIGH  = 12'h324;

   // ------------------------------------------------------------------
   // implemented event positions, reset values, fixed read values
   // ------------------------------------------------------------------
   // low word: events 7:1, 13:12, 16:15, 19:18, 23:22, 31:27
   localparam logic [DATA_W-1:0] MASK_LOW    = 32'hf8cdb0fe;
   // high word: events 38:32 at bits 6:0, events 41:40 at bits 9:8
   localparam logic [DATA_W-1:0] MASK_HIGH   = 32'h0000037f;
   localparam logic [DATA_W-1:0] RESET_WORD  = 32'h00000000;
   localparam logic [DATA_W-1:0] READ_ZERO   = 32'h00000000;

   // ------------------------------------------------------------------
   // carrier: one bit per event number, low word holds events 31:0
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [DATA_W-1:0] high;
      logic [DATA_W-1:0] low;
   } ttes_events_t;

endpackage : ttes_pkg

// ===== rtl/ttes_enable_word.sv
// one 32-bit word of event enable status flags
// assumes set, clear and done are one-cycle pulses in the clk domain
`timescale 1ns/1ps
module ttes_enable_word #(
   parameter logic [31:0] MASK = 32'h00000000
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [31:0] setBits,
   input  wire logic [31:0] clearBits,
   input  wire logic [31:0] doneBits,
   output logic      [31:0] status
);

   // ------------------------------------------------------------------
   // per-event flags
   // ------------------------------------------------------------------
   for (genvar i = 0; i < 32; i++) begin : g_bit
      if (MASK[i]) begin : g_impl
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               status[i] <= 1'b0;
            end else if (setBits[i]) begin
               status[i] <= 1'b1;
            end else if (clearBits[i] || doneBits[i]) begin
               status[i] <= 1'b0;
            end
         end
      end else begin : g_resv
         assign status[i] = 1'b0;
      end
   end

endmodule : ttes_enable_word

// ===== rtl/ttes_trigger_enable.sv
// APB register bank: write-one-to-set and write-one-to-clear event trigger enables,
// plus read-only enable status, for the transfer controller
// assumes APB master per the published protocol; xferDone pulses come from the
// transfer controller, one cycle per finished event (after the last chain link)
//
// Summary of operation
// - writing 1 to an event's set bit enables that event as trigger.
// - writing 0 to a set bit leaves that event's enable unchanged.
// - set bits always read back as 0.
// - reserved positions read 0 and writes there change nothing.
// - low set word bit i controls event i on the implemented positions.
// - high set word bit i controls event i+32; bit 7 and 31:10 reserved.
// - each set bit selects exactly one transfer controller vector.
// - status is read-only; set by set bit, cleared by clear bit.
// - completion of an event's transfers clears its enable status, unless a set write for it lands in the same cycle.
// - writing 1 to a clear bit disables the event; 0 does nothing.
`timescale 1ns/1ps
module ttes_trigger_enable (
   input  wire logic                        clk,
   input  wire logic                        nrst,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ttes_pkg::ADDR_W-1:0] paddr,
   input  wire logic [ttes_pkg::DATA_W-1:0] pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic      [ttes_pkg::DATA_W-1:0] prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire ttes_pkg::ttes_events_t      xferDone,
   output ttes_pkg::ttes_events_t           trigEnable
);

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   function automatic logic hitReg(input logic [ttes_pkg::ADDR_W-1:0] a,
                                   input logic [ttes_pkg::ADDR_W-1:0] off);
      hitReg = (a == off);
   endfunction : hitReg

   function automatic logic isMapped(input logic [ttes_pkg::ADDR_W-1:0] a);
      isMapped = hitReg(a, ttes_pkg::OFF_STATUS_LOW) || hitReg(a, ttes_pkg::OFF_STATUS_HIGH)
              || hitReg(a, ttes_pkg::OFF_SET_LOW)    || hitReg(a, ttes_pkg::OFF_SET_HIGH)
              || hitReg(a, ttes_pkg::OFF_CLEAR_LOW)  || hitReg(a, ttes_pkg::OFF_CLEAR_HIGH);
   endfunction : isMapped

   logic                        setupPhase;
   logic                        wrCommit;
   logic [ttes_pkg::DATA_W-1:0] wdata;
   logic [ttes_pkg::DATA_W-1:0] setLow;
   logic [ttes_pkg::DATA_W-1:0] setHigh;
   logic [ttes_pkg::DATA_W-1:0] clrLow;
   logic [ttes_pkg::DATA_W-1:0] clrHigh;
   logic [ttes_pkg::DATA_W-1:0] next_rdata;

   assign setupPhase = psel && !penable;
   // status registers are read-only, so a write there is accepted and dropped
   assign wrCommit   = psel && penable && pready && pwrite && !pslverr;

   // byte strobes gate write-one bits so a partial write never touches other lanes
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wdata[8*b +: 8] = pwdata[8*b +: 8] & {8{pstrb[b]}};
   end

   // ------------------------------------------------------------------
   // write-one pulses
   // ------------------------------------------------------------------
   // zeros and reserved masked
   assign setLow  = (wrCommit && hitReg(paddr, ttes_pkg::OFF_SET_LOW))
                    ? (wdata & ttes_pkg::MASK_LOW)  : ttes_pkg::READ_ZERO;
   // high word maps event minus 32
   assign setHigh = (wrCommit && hitReg(paddr, ttes_pkg::OFF_SET_HIGH))
                    ? (wdata & ttes_pkg::MASK_HIGH) : ttes_pkg::READ_ZERO;
   assign clrLow  = (wrCommit && hitReg(paddr, ttes_pkg::OFF_CLEAR_LOW))
                    ? (wdata & ttes_pkg::MASK_LOW)  : ttes_pkg::READ_ZERO;
   assign clrHigh = (wrCommit && hitReg(paddr, ttes_pkg::OFF_CLEAR_HIGH))
                    ? (wdata & ttes_pkg::MASK_HIGH) : ttes_pkg::READ_ZERO;

   // ------------------------------------------------------------------
   // enable status words
   // ------------------------------------------------------------------
   ttes_enable_word #(.MASK(ttes_pkg::MASK_LOW)) u_word_low (
      .clk       (clk),
      .nrst      (nrst),
      .setBits   (setLow),
      .clearBits (clrLow),
      .doneBits  (xferDone.low),
      .status    (trigEnable.low)
   );

   ttes_enable_word #(.MASK(ttes_pkg::MASK_HIGH)) u_word_high (
      .clk       (clk),
      .nrst      (nrst),
      .setBits   (setHigh),
      .clearBits (clrHigh),
      .doneBits  (xferDone.high),
      .status    (trigEnable.high)
   );

   // ------------------------------------------------------------------
   // read data
   // ------------------------------------------------------------------
   always_comb begin
      // set and clear words read zero
      next_rdata = ttes_pkg::READ_ZERO;
      if (hitReg(paddr, ttes_pkg::OFF_STATUS_LOW)) begin
         next_rdata = trigEnable.low;
      end else if (hitReg(paddr, ttes_pkg::OFF_STATUS_HIGH)) begin
         next_rdata = trigEnable.high;
      end
   end

   // ------------------------------------------------------------------
   // APB answer: one access cycle, registered
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= ttes_pkg::RESET_WORD;
      end else if (setupPhase) begin
         pready  <= 1'b1;
         pslverr <= !isMapped(paddr);
         prdata  <= pwrite ? ttes_pkg::READ_ZERO : next_rdata;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= ttes_pkg::READ_ZERO;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_set_enables: assert property (
      (setLow != 0) |=> ((trigEnable.low & $past(setLow)) == $past(setLow)))
      else $error("set write did not enable its event");

   chk_set_zero_keeps: assert property (
      (setLow != 0 || setHigh != 0) && xferDone == '0 |=>
         ((~trigEnable & $past(trigEnable)) == '0))
      else $error("set write disabled an event");

   chk_set_reads_zero: assert property (
      setupPhase && !pwrite && (hitReg(paddr, ttes_pkg::OFF_SET_LOW)
         || hitReg(paddr, ttes_pkg::OFF_SET_HIGH)) |=> pready && prdata == 32'h00000000)
      else $error("set word read back nonzero");

   chk_low_reserved: assert property (
      (trigEnable.low & ~ttes_pkg::MASK_LOW) == 32'h00000000)
      else $error("reserved low position set");

   chk_high_reserved: assert property (
      (trigEnable.high & ~ttes_pkg::MASK_HIGH) == 32'h00000000)
      else $error("reserved high position set");

   chk_status_read: assert property (
      setupPhase && !pwrite && hitReg(paddr, ttes_pkg::OFF_STATUS_HIGH)
         |=> prdata == $past(trigEnable.high))
      else $error("status read mismatch");

   chk_no_stray_set: assert property (
      ##1 ((trigEnable.low & ~$past(trigEnable.low) & ~$past(setLow)) == 32'h00000000))
      else $error("enable rose without a set write");

   chk_done_clears: assert property (
      (xferDone.high & ~setHigh) != 0 |=>
         ((trigEnable.high & $past(xferDone.high) & ~$past(setHigh)) == 32'h00000000))
      else $error("completion did not clear enable");

   chk_clear_write: assert property (
      (clrLow != 0) && setLow == 0 |=> ((trigEnable.low & $past(clrLow)) == 32'h00000000))
      else $error("clear write did not disable event");

   chk_set_wins: assert property (
      (setLow & xferDone.low) != 0 |=>
         ((trigEnable.low & $past(setLow & xferDone.low)) == $past(setLow & xferDone.low)))
      else $error("completion beat a set write");

   chk_answer_one: assert property (
      setupPhase |=> pready ##1 !pready)
      else $error("pready not a single access cycle");

   chk_ready_setup: assert property (
      pready |-> $past(setupPhase))
      else $error("pready without a setup cycle");

   chk_unmapped_err: assert property (
      setupPhase && !isMapped(paddr) |=> pready && pslverr)
      else $error("unmapped offset gave no error");

   chk_mapped_ok: assert property (
      setupPhase && isMapped(paddr) |=> pready && !pslverr)
      else $error("mapped offset gave an error");

   chk_idle_quiet: assert property (
      !pready |-> !pslverr && prdata == 32'h00000000)
      else $error("answer outputs active outside access");

   chk_write_rdata: assert property (
      setupPhase && pwrite |=> prdata == 32'h00000000)
      else $error("write cycle returned read data");

   chk_clear_reads_zero: assert property (
      setupPhase && !pwrite && (hitReg(paddr, ttes_pkg::OFF_CLEAR_LOW)
         || hitReg(paddr, ttes_pkg::OFF_CLEAR_HIGH)) |=> prdata == 32'h00000000)
      else $error("clear word read back nonzero");

   chk_unmapped_write_ign: assert property (
      psel && penable && pready && pslverr && pwrite && xferDone == '0
         |=> trigEnable == $past(trigEnable))
      else $error("unmapped write changed an enable");

   // ------------------------------------------------------------------
   // checks: enable status paths
   // ------------------------------------------------------------------
   // the two words are separate instances, so each word gets its own check, except the one-vector check, which covers the high word only
   chk_set_enables_hi: assert property (
      (setHigh != 0) |=> ((trigEnable.high & $past(setHigh)) == $past(setHigh)))
      else $error("high set write did not enable its event");

   chk_zero_bits_low: assert property (
      wrCommit && hitReg(paddr, ttes_pkg::OFF_SET_LOW) && xferDone.low == 32'h00000000
         |=> (((trigEnable.low ^ $past(trigEnable.low)) & ~$past(setLow)) == 32'h00000000))
      else $error("set write changed an unwritten low event");

   chk_zero_bits_high: assert property (
      wrCommit && hitReg(paddr, ttes_pkg::OFF_SET_HIGH) && xferDone.high == 32'h00000000
         |=> (((trigEnable.high ^ $past(trigEnable.high)) & ~$past(setHigh)) == 32'h00000000))
      else $error("set write changed an unwritten high event");

   chk_set_only_ones: assert property (
      (setLow & ~pwdata) == 32'h00000000 && (setHigh & ~pwdata) == 32'h00000000)
      else $error("set pulse on a bit written 0");

   chk_resv_no_pulse: assert property (
      ((setLow | clrLow) & ~ttes_pkg::MASK_LOW) == 32'h00000000
         && ((setHigh | clrHigh) & ~ttes_pkg::MASK_HIGH) == 32'h00000000)
      else $error("write pulse on a reserved position");

   chk_one_vector: assert property (
      (setHigh & ~trigEnable.high) != 0 && $onehot(setHigh) && xferDone.high == 32'h00000000
         |=> $onehot(trigEnable.high ^ $past(trigEnable.high)))
      else $error("one set bit moved other than one event");

   chk_status_read_lo: assert property (
      setupPhase && !pwrite && hitReg(paddr, ttes_pkg::OFF_STATUS_LOW)
         |=> prdata == $past(trigEnable.low))
      else $error("low status read mismatch");

   chk_status_write_ign: assert property (
      wrCommit && (hitReg(paddr, ttes_pkg::OFF_STATUS_LOW)
         || hitReg(paddr, ttes_pkg::OFF_STATUS_HIGH)) && xferDone == '0
         |=> trigEnable == $past(trigEnable))
      else $error("status write changed an enable");

   chk_no_stray_hi: assert property (
      ##1 ((trigEnable.high & ~$past(trigEnable.high) & ~$past(setHigh)) == 32'h00000000))
      else $error("high enable rose without a set write");

   chk_fall_cause_lo: assert property (
      ##1 ((~trigEnable.low & $past(trigEnable.low) & ~$past(clrLow | xferDone.low))
         == 32'h00000000))
      else $error("low enable fell without clear or completion");

   chk_fall_cause_hi: assert property (
      ##1 ((~trigEnable.high & $past(trigEnable.high) & ~$past(clrHigh | xferDone.high))
         == 32'h00000000))
      else $error("high enable fell without clear or completion");

   chk_done_clears_lo: assert property (
      (xferDone.low & ~setLow) != 0 |=>
         ((trigEnable.low & $past(xferDone.low) & ~$past(setLow)) == 32'h00000000))
      else $error("completion did not clear low enable");

   chk_clear_write_hi: assert property (
      (clrHigh != 0) && setHigh == 0 |=> ((trigEnable.high & $past(clrHigh)) == 32'h00000000))
      else $error("high clear write did not disable event");

   chk_clear_keeps_lo: assert property (
      wrCommit && hitReg(paddr, ttes_pkg::OFF_CLEAR_LOW) && xferDone.low == 32'h00000000
         |=> (((trigEnable.low ^ $past(trigEnable.low)) & ~$past(clrLow)) == 32'h00000000))
      else $error("clear write changed an unwritten low event");

   chk_clear_keeps_hi: assert property (
      wrCommit && hitReg(paddr, ttes_pkg::OFF_CLEAR_HIGH) && xferDone.high == 32'h00000000
         |=> (((trigEnable.high ^ $past(trigEnable.high)) & ~$past(clrHigh)) == 32'h00000000))
      else $error("clear write changed an unwritten high event");

   chk_set_wins_hi: assert property (
      (setHigh & xferDone.high) != 0 |=>
         ((trigEnable.high & $past(setHigh & xferDone.high)) == $past(setHigh & xferDone.high)))
      else $error("completion beat a high set write");

endmodule : ttes_trigger_enable

// ===== testbench/ttes_done_model.sv
// partner model: completion pulses of the transfer controller
// assumes the bench raises fire for one cycle with the events to finish
`timescale 1ns/1ps
module ttes_done_model (
   input  wire logic                   clk,
   input  wire logic                   nrst,
   input  wire logic                   fire,
   input  wire ttes_pkg::ttes_events_t doneReq,
   output ttes_pkg::ttes_events_t      xferDone
);
   // ---------------------------------------------------------------
   // completion pulses
   // ---------------------------------------------------------------
   // one-cycle finish pulse
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) xferDone <= '0;
      else xferDone <= fire ? doneReq : '0;
   end
endmodule : ttes_done_model

// ===== testbench/ttes_trigger_enable_tb_top.sv
// self-checking bench for the trigger enable register bank
// assumes ttes_pkg and the completion model are compiled before it
`timescale 1ns/1ps
module ttes_trigger_enable_tb_top;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic                   clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
   logic [11:0]            paddr = '0;
   logic [31:0]            pwdata = '0, prdata;
   logic [3:0]             pstrb = '0;
   logic                   pready, pslverr;
   ttes_pkg::ttes_events_t xferDone, trigEnable, doneReq = '0, exp = '0, dn;
   logic [33:0]            q[$], nt;
   logic [11:0]            offs[7] = '{12'h300, 12'h304, 12'h310, 12'h314, 12'h320,
                                       12'h324, 12'h3f0};
   int                     badCount = 0, checks = 0, cyc = 0, seed = 51;
   always #10 clk = ~clk;
   ttes_trigger_enable dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .xferDone(xferDone), .trigEnable(trigEnable));
   ttes_done_model partner (.clk(clk), .nrst(nrst), .fire(fire), .doneReq(doneReq),
      .xferDone(xferDone));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   // one APB transfer; d2 finishes events in the access cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input ttes_pkg::ttes_events_t d2);
      logic [31:0] m;
      logic        err;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      err = !(a inside {12'h300, 12'h304, 12'h310, 12'h314, 12'h320, 12'h324});
      q.push_back({!w, err, (a == 12'h300) ? exp.low : (a == 12'h304) ? exp.high : 32'h0});
      // set is applied after the finish clear, so it wins
      exp = exp & ~d2;
      if (w && a == 12'h310) exp.low = exp.low | (d & m & ttes_pkg::MASK_LOW);
      if (w && a == 12'h314) exp.high = exp.high | (d & m & ttes_pkg::MASK_HIGH);
      if (w && a == 12'h320) exp.low = exp.low & ~(d & m);
      if (w && a == 12'h324) exp.high = exp.high & ~(d & m);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      // reads drive no strobes, as the bus protocol asks
      pstrb <= w ? s : 4'h0;
      doneReq <= d2;
      fire <= |d2;
      @(posedge clk);
      penable <= 1;
      fire <= 0;
      // only pready or the bench timeout ends this wait
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask : apb
   // ---------------------------------------------------------------
   // monitor and timeout
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin badCount++; $display("[ERR] %0t timeout", $time); give_verdict(); end
      if (psel && penable && pready) begin
         nt = q.pop_front();
         checks++;
         if (pslverr !== nt[32] || (nt[33] && prdata !== nt[31:0])) begin
            badCount++;
            $display("[ERR] %0t at %h got %b %h want %b %h", $time, paddr, pslverr, prdata,
                     nt[32], nt[31:0]);
         end
      end
   end
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1;
      foreach (offs[i]) apb(0, offs[i], 0, 4'hf, '0);
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         apb(1, i[0] ? 12'h314 : 12'h310, $random(seed) & $random(seed)
             & (i[0] ? ttes_pkg::MASK_HIGH : ttes_pkg::MASK_LOW), 4'($random(seed)), '0);
         apb(0, i[0] ? 12'h304 : 12'h300, 0, 4'hf, '0);
         apb(0, i[0] ? 12'h314 : 12'h310, 0, 4'hf, '0);
      end
      $display("test random set done");
      apb(1, 12'h300, 32'hffffffff, 4'hf, '0);
      apb(1, 12'h3f0, 32'hffffffff, 4'hf, '0);
      apb(1, 12'h310, 32'h0, 4'hf, '0);
      apb(1, 12'h314, 32'hffffffff, 4'hf, '0);
      apb(0, 12'h304, 0, 4'hf, '0);
      apb(1, 12'h320, 32'h0, 4'hf, '0);
      apb(1, 12'h320, $random(seed), 4'hf, '0);
      apb(1, 12'h324, 32'h00000155, 4'hf, '0);
      apb(1, 12'h314, 32'h00000010, 4'hf, '0);
      apb(0, 12'h300, 0, 4'hf, '0);
      apb(0, 12'h304, 0, 4'hf, '0);
      $display("test clear done");
      apb(1, 12'h310, 32'hffffffff, 4'hf, '0);
      for (int i = 0; i < 6; i++) begin
         dn = {$random(seed), $random(seed)};
         apb(i[0], i[0] ? (i[1] ? 12'h314 : 12'h310) : 12'h300,
             $random(seed) & (i[1] ? ttes_pkg::MASK_HIGH : ttes_pkg::MASK_LOW), 4'hf, dn);
         apb(0, 12'h300, 0, 4'hf, '0);
         apb(0, 12'h304, 0, 4'hf, '0);
      end
      $display("test finish pulse done");
      @(posedge clk);
      checks++;
      if (trigEnable !== exp) begin badCount++; $display("[ERR] %0t enable vector", $time); end
      give_verdict();
   end
endmodule : ttes_trigger_enable_tb_top
